// ### hw/rfd_decoder.sv
// Purpose: Register file and program memory address decode with on-chip RAM.
// Assumes: One requester; reads answer one cycle after the request.
// Notes: Control register bank sits outside, reached through ctrl strobes.
`timescale 1ns/1ns
`include "rfd_params.svh"
module rfd_decoder #(
    parameter int RAM_BYTES = `RFD_RAM_DEFAULT,
    parameter int FLASH_BYTES = `RFD_FLASH_DEFAULT
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire rfd_pkg::rfd_req_s req_i,
    input wire logic [`RFD_DATA_W-1:0] ctrl_rdata_i,
    input wire rfd_pkg::rfd_preq_s preq_i,
    output rfd_pkg::rfd_target_e target_o,
    output logic ctrl_rd_o,
    output logic ctrl_wr_o,
    output logic [7:0] ctrl_addr_o,
    output logic [`RFD_DATA_W-1:0] ctrl_wdata_o,
    output logic [`RFD_DATA_W-1:0] rdata_o,
    output logic rvalid_o,
    output logic flash_sel_o,
    output logic [`RFD_PMEM_ADDR_W-1:0] flash_addr_o
);
    localparam int RAM_AW = $clog2(RAM_BYTES);
    localparam logic [`RFD_ADDR_W-1:0] RAM_LAST = 12'(RAM_BYTES - 1);

    // Elaboration-time range check of the build parameters.
    if (RAM_BYTES < `RFD_RAM_MIN || RAM_BYTES > `RFD_RAM_MAX) begin : g_bad_ram
        $error("RAM size parameter is outside the supported range.");
    end
    if (FLASH_BYTES < `RFD_FLASH_MIN || FLASH_BYTES > `RFD_FLASH_MAX) begin : g_bad_flash
        $error("Flash size parameter is outside the supported range.");
    end

    function automatic rfd_pkg::rfd_target_e decode(input logic [`RFD_ADDR_W-1:0] a);
        if (a >= `RFD_CTRL_BASE) begin
            decode = rfd_pkg::RFD_TGT_CTRL;
        end else if ({20'h0, a} < RAM_BYTES) begin
            decode = rfd_pkg::RFD_TGT_RAM;
        end else begin
            decode = rfd_pkg::RFD_TGT_NONE;
        end
    endfunction

    logic [`RFD_DATA_W-1:0] ram [RAM_BYTES];
    logic [`RFD_DATA_W-1:0] ram_q;
    logic ram_rd_q;
    logic ctrl_rd_q;
    logic rd_any_q;

    wire rfd_pkg::rfd_target_e tgt = decode(req_i.addr);
    wire ram_sel = (tgt == rfd_pkg::RFD_TGT_RAM);
    wire ctrl_sel = (tgt == rfd_pkg::RFD_TGT_CTRL);
    wire ram_we = req_i.wr && ram_sel;
    // Only the low address bits index RAM; the decode keeps gap and control writes away from it.
    wire [RAM_AW-1:0] ram_addr = req_i.addr[RAM_AW-1:0];

    assign target_o = tgt;
    assign ctrl_rd_o = req_i.rd && ctrl_sel;
    assign ctrl_wr_o = req_i.wr && ctrl_sel;
    assign ctrl_addr_o = req_i.addr[7:0];
    assign ctrl_wdata_o = req_i.wdata;
    // Unpopulated reads are not defined; a fixed fill is returned. Every control read returns ctrl_rdata_i.
    assign rdata_o = ram_rd_q ? ram_q : (ctrl_rd_q ? ctrl_rdata_i : `RFD_FILL_DATA);
    assign rvalid_o = rd_any_q;

    assign flash_sel_o = preq_i.rd && ({16'h0, preq_i.addr} < FLASH_BYTES);
    assign flash_addr_o = preq_i.addr;

    // RAM has no reset so that it maps onto a plain synchronous memory.
    always_ff @(posedge sys_clk_i) begin
        if (ram_we) begin
            ram[ram_addr] <= req_i.wdata;
        end
        ram_q <= ram[ram_addr];
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ram_rd_q <= 1'b0;
            ctrl_rd_q <= 1'b0;
            rd_any_q <= 1'b0;
        end else begin
            ram_rd_q <= req_i.rd && ram_sel;
            ctrl_rd_q <= req_i.rd && ctrl_sel;
            rd_any_q <= req_i.rd;
        end
    end

    // Helper tracking of the last RAM write, for the read-back check.
    logic [`RFD_ADDR_W-1:0] last_wa;
    logic [`RFD_DATA_W-1:0] last_wd;
    logic last_wv;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            last_wv <= 1'b0;
            last_wa <= 12'h000;
            last_wd <= 8'h00;
        end else if (ram_we) begin
            last_wv <= 1'b1;
            last_wa <= req_i.addr;
            last_wd <= req_i.wdata;
        end
    end

    sequence s_ram_read;
        req_i.rd && ram_sel && !req_i.wr;
    endsequence

    sequence s_ram_write;
        req_i.wr && ram_sel && !req_i.rd;
    endsequence

    sequence s_gap_access;
        ({20'h0, req_i.addr} >= RAM_BYTES) && (req_i.addr < `RFD_CTRL_BASE);
    endsequence

    sequence s_gap_read;
        s_gap_access ##0 req_i.rd;
    endsequence

    sequence s_gap_write;
        s_gap_access ##0 req_i.wr;
    endsequence

    ctrl_region_sel_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.addr >= 12'hf00) |-> (target_o == rfd_pkg::RFD_TGT_CTRL && !ram_we))
        else $error("Control region address not routed to control bank.");
    one_target_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $onehot0({ram_sel, ctrl_sel}) && (ram_sel || ctrl_sel || tgt == rfd_pkg::RFD_TGT_NONE))
        else $error("Target select not unique.");
    ram_bound_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.addr < 12'hf00) |-> (ram_sel == ({20'h0, req_i.addr} < RAM_BYTES)))
        else $error("RAM decode does not match configured size.");
    ram_base_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.addr == 12'h000) |-> ram_sel)
        else $error("RAM does not start at address zero.");
    gap_no_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.wr && tgt == rfd_pkg::RFD_TGT_NONE) |-> (!ram_we && !ctrl_wr_o))
        else $error("Write to unpopulated space reached storage.");
    ram_readback_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (s_ram_read and (last_wv && req_i.addr == last_wa)) |=> (rvalid_o && rdata_o == $past(last_wd)))
        else $error("RAM read did not return last written byte.");
    ctrl_read_path_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.rd && ctrl_sel) |=> (rvalid_o && rdata_o == ctrl_rdata_i))
        else $error("Control read data not forwarded.");
    read_latency_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i.rd |=> rvalid_o ##1 (rvalid_o == $past(req_i.rd)))
        else $error("Read answer not one cycle after request.");
    flash_bound_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        preq_i.rd |-> (flash_sel_o == ({16'h0, preq_i.addr} < FLASH_BYTES)))
        else $error("Flash select does not match populated size.");

    // Control region routing and forwarding.
    ctrl_strobes_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (ctrl_rd_o == (req_i.rd && req_i.addr >= `RFD_CTRL_BASE))
        && (ctrl_wr_o == (req_i.wr && req_i.addr >= `RFD_CTRL_BASE)))
        else $error("Control strobes do not follow the request.");
    ctrl_fwd_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (ctrl_addr_o == req_i.addr[7:0]) && (ctrl_wdata_o == req_i.wdata))
        else $error("Control address or data not forwarded.");
    ctrl_idle_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.addr < `RFD_CTRL_BASE) |-> (!ctrl_rd_o && !ctrl_wr_o))
        else $error("Control strobe raised below the control region.");
    ram_no_ctrl_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ram_sel |-> (!ctrl_rd_o && !ctrl_wr_o))
        else $error("RAM and control bank selected together.");

    // Unpopulated space between RAM and the control region.
    gap_no_target_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_gap_access |-> (target_o == rfd_pkg::RFD_TGT_NONE && !ctrl_rd_o && !ctrl_wr_o))
        else $error("Unpopulated address selected a target.");
    gap_read_answer_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_gap_read |=> rvalid_o)
        else $error("Read of unpopulated space got no answer.");
    gap_write_drop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_gap_write |-> (!ram_we && !ctrl_wr_o))
        else $error("Write to unpopulated space was not dropped.");

    // RAM placement and size.
    ram_low_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ({20'h0, req_i.addr} < RAM_BYTES) |-> (target_o == rfd_pkg::RFD_TGT_RAM))
        else $error("Address inside RAM not routed to RAM.");
    ram_last_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.addr == RAM_LAST) |-> ram_sel)
        else $error("Last RAM byte not selected.");
    ram_end_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.addr == RAM_LAST + 12'h001) |-> !ram_sel)
        else $error("Byte past the RAM end selected as RAM.");

    // Read answers.
    write_no_answer_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.wr && !req_i.rd) |=> !rvalid_o)
        else $error("Write produced a read answer.");
    ram_write_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (s_ram_write ##1 (s_ram_read and (req_i.addr == $past(req_i.addr))))
        |=> (rvalid_o && rdata_o == $past(req_i.wdata, 2)))
        else $error("Back-to-back RAM write and read disagree.");
    one_answer_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rvalid_o |-> $past(req_i.rd))
        else $error("Read answer without a read request.");
    // Reset is not disabled here: the answer flops must clear while it is held.
    reset_quiet_a: assert property (@(posedge sys_clk_i)
        srst_i |=> (!rvalid_o && rdata_o == `RFD_FILL_DATA))
        else $error("Read answer not cleared by reset.");

    // Program memory and target encoding.
    flash_rd_only_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !preq_i.rd |-> !flash_sel_o)
        else $error("Flash selected without a read.");
    flash_addr_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        flash_addr_o == preq_i.addr)
        else $error("Flash address not forwarded.");
    target_legal_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        target_o inside {rfd_pkg::RFD_TGT_NONE, rfd_pkg::RFD_TGT_RAM, rfd_pkg::RFD_TGT_CTRL})
        else $error("Target code outside the legal set.");
endmodule

// ### inc/rfd_params.svh
// Purpose: Constants for the register file address decoder.
// Assumes: Byte-wide register file with a twelve-bit address.
// Notes: Definitions only.
`ifndef RFD_PARAMS_SVH
`define RFD_PARAMS_SVH
`define RFD_ADDR_W 12
`define RFD_DATA_W 8
`define RFD_SPACE_BYTES 4096
`define RFD_CTRL_BASE 12'hf00
`define RFD_CTRL_TOP 12'hfff
`define RFD_RAM_BASE 12'h000
`define RFD_RAM_MIN 256
`define RFD_RAM_MAX 1024
`define RFD_RAM_DEFAULT 1024
`define RFD_PMEM_ADDR_W 16
`define RFD_FLASH_MIN 1024
`define RFD_FLASH_MAX 8192
`define RFD_FLASH_DEFAULT 8192
`define RFD_FILL_DATA 8'h00
`endif

// ### inc/rfd_pkg.sv
// Purpose: Types for the register file address decoder.
// Assumes: Constants come from rfd_params.svh.
// Notes: None.
`include "rfd_params.svh"
package rfd_pkg;
    typedef enum logic [1:0] {
        RFD_TGT_NONE,
        RFD_TGT_RAM,
        RFD_TGT_CTRL
    } rfd_target_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [`RFD_ADDR_W-1:0] addr;
        logic [`RFD_DATA_W-1:0] wdata;
    } rfd_req_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [`RFD_PMEM_ADDR_W-1:0] addr;
    } rfd_preq_s;
endpackage

// ### tb/rfd_ctrl_model.sv
// Purpose: Control register bank standing behind the decoder.
// Assumes: Read data is due one cycle after the read strobe.
// Notes: All 256 locations hold plain storage.
`timescale 1ns/1ns
module rfd_ctrl_model (
    input wire logic sys_clk_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [256];
    initial rdata_o = 8'h00;
    // Outside a read answer the data toggles, so stale data cannot pass for a match.
    always @(posedge sys_clk_i) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
    end
endmodule

// ### tb/rfd_decoder_tb_top.sv
// Purpose: Self-checking bench for the register file decoder.
// Assumes: A 256-byte RAM build and an 8 KB flash build.
// Notes: Inputs change at the falling edge.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module rfd_decoder_tb_top;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    rfd_pkg::rfd_req_s req = '0;
    rfd_pkg::rfd_preq_s preq = '0;
    rfd_pkg::rfd_target_e tgt;
    logic crd, cwr, rv, fsel;
    logic [7:0] caddr, cwd, crdata, rdata, q;
    logic [15:0] faddr;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    rfd_decoder #(.RAM_BYTES(256), .FLASH_BYTES(8192)) rfd_decoder_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .req_i(req), .ctrl_rdata_i(crdata), .preq_i(preq), .target_o(tgt), .ctrl_rd_o(crd), .ctrl_wr_o(cwr),
        .ctrl_addr_o(caddr), .ctrl_wdata_o(cwd), .rdata_o(rdata), .rvalid_o(rv), .flash_sel_o(fsel),
        .flash_addr_o(faddr));
    rfd_ctrl_model rfd_ctrl_model_i (.sys_clk_i(sys_clk_i), .rd_i(crd), .wr_i(cwr), .addr_i(caddr),
        .wdata_i(cwd), .rdata_o(crdata));
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic xfer(input logic r, input logic w, input logic [11:0] a, input logic [7:0] d,
                        input rfd_pkg::rfd_target_e t);
        req = {r, w, a, d};
        #1;
        `CHK(tgt, t)
        `CHK({crd, cwr, caddr, cwd}, {r & a[11:8] == 4'hf, w & a[11:8] == 4'hf, a[7:0], d})
        @(negedge sys_clk_i);
        `CHK(rv, r)
        q = rdata;
    endtask
    task automatic idle();
        req = '0;
        @(negedge sys_clk_i);
    endtask
    task automatic ram_case();
        xfer(0, 1, 12'h000, 8'h3c, rfd_pkg::RFD_TGT_RAM);
        xfer(0, 1, 12'h0ff, 8'hc3, rfd_pkg::RFD_TGT_RAM);
        xfer(1, 0, 12'h000, 8'h00, rfd_pkg::RFD_TGT_RAM);
        `CHK(q, 8'h3c)
        xfer(1, 0, 12'h0ff, 8'h00, rfd_pkg::RFD_TGT_RAM);
        `CHK(q, 8'hc3)
        xfer(0, 1, 12'h080, 8'h81, rfd_pkg::RFD_TGT_RAM);
        xfer(1, 0, 12'h080, 8'h00, rfd_pkg::RFD_TGT_RAM);
        `CHK(q, 8'h81)
        idle();
    endtask
    task automatic gap_case();
        xfer(0, 1, 12'h100, 8'h99, rfd_pkg::RFD_TGT_NONE);
        xfer(0, 1, 12'heff, 8'h99, rfd_pkg::RFD_TGT_NONE);
        xfer(1, 0, 12'h100, 8'h00, rfd_pkg::RFD_TGT_NONE);
        xfer(1, 0, 12'h000, 8'h00, rfd_pkg::RFD_TGT_RAM);
        `CHK(q, 8'h3c)
        xfer(1, 0, 12'h0ff, 8'h00, rfd_pkg::RFD_TGT_RAM);
        `CHK(q, 8'hc3)
        idle();
    endtask
    task automatic ctrl_case();
        xfer(0, 1, 12'hf00, 8'h5a, rfd_pkg::RFD_TGT_CTRL);
        xfer(0, 1, 12'hfff, 8'ha5, rfd_pkg::RFD_TGT_CTRL);
        xfer(1, 0, 12'hf00, 8'h00, rfd_pkg::RFD_TGT_CTRL);
        `CHK(q, 8'h5a)
        xfer(1, 0, 12'hfff, 8'h00, rfd_pkg::RFD_TGT_CTRL);
        `CHK(q, 8'ha5)
        idle();
    endtask
    task automatic reset_case();
        req = {1'b1, 1'b0, 12'h000, 8'h00};
        srst_i = 1'b1;
        @(negedge sys_clk_i);
        `CHK({rv, rdata}, 9'h000)
        srst_i = 1'b0;
        @(negedge sys_clk_i);
        `CHK(rv, 1'b1)
        idle();
        `CHK(rv, 1'b0)
    endtask
    task automatic flash_case();
        preq = {2'b10, 16'h1fff};
        #1;
        `CHK({fsel, faddr}, {1'b1, 16'h1fff})
        @(negedge sys_clk_i);
        preq = {2'b10, 16'h2000};
        #1;
        `CHK(fsel, 1'b0)
        @(negedge sys_clk_i);
        preq = {2'b01, 16'h0100};
        #1;
        `CHK(fsel, 1'b0)
        @(negedge sys_clk_i);
        preq = '0;
    endtask
    initial begin
        repeat (16) @(negedge sys_clk_i);
        srst_i = 1'b0;
        `CHK({rv, rdata}, 9'h000)
        ram_case();
        gap_case();
        ctrl_case();
        reset_case();
        flash_case();
        wrap_up();
    end
endmodule
